// >>> core/dual_timer.sv
// dual 16-bit timer/counter with mode register and wishbone slave
//
// Overview of operation
// - mode register index 89, reset zero, byte-wide
// - timer 1 gate: count only while irq1 pin high
// - timer 1 source: event pin or machine tick
// - timer 1 mode 0: prescaled 8-bit high byte
// - timer 1 mode 1: cascaded 16-bit counter
// - timer 1 mode 2: low byte auto-reloads from high
// - timer 0 gate: count only while irq0 pin high
// - timer 0 source: event pin or machine tick
// - timer 0 mode 0: prescaled 8-bit high byte
// - timer 0 mode 1: cascaded 16-bit counter
// - timer 0 mode 2: low byte auto-reloads from high
// - timer 0 mode 3: low byte own controls
// - mode 3: high byte uses timer 1 run bit and flag
// - internal tick every 12 core clocks
// - event counted on sampled high-then-low pair
// - each timer runs only while run bit set
// - overflow sets flag, vector entry clears it
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module dual_timer
	import dual_timer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	input wire logic extIrq0Pin,
	input wire logic extIrq1Pin,
	input wire logic timer0EventPin,
	input wire logic timer1EventPin,
	input wire logic vectorAck0,
	input wire logic vectorAck1,
	output logic irq
);
	logic tick, fall0, fall1;
	logic [7:0] timerModeRegister, modeActive, regRead, idx, wrByte;
	logic [7:0] timer0LowByte, timer0HighByte, timer1LowByte, timer1HighByte;
	logic timer0RunBit, timer1RunBit, timer0OverflowFlag, timer1OverflowFlag;
	logic [1:0] irqStatus, irqMask;
	logic wrHit, rdHit, run0, run1, inc0, inc1, incHi0, ovf0, ovf1;
	timer_mode_t mode0, mode1;
	logic [16:0] step0, step1;
	logic [7:0] timerControlRegister;

	////////////////////////////////////////////////////////////////////
	// tick and event sampling
	machine_cycle_gen #(.DIV(MCYCLE_CLOCKS)) u_cycle (.ref_clk(ref_clk), .rst(rst),
		.tick(tick));
	event_edge_sampler u_evt0 (.ref_clk(ref_clk), .rst(rst), .tick(tick),
		.pin(timer0EventPin), .fall(fall0));
	event_edge_sampler u_evt1 (.ref_clk(ref_clk), .rst(rst), .tick(tick),
		.pin(timer1EventPin), .fall(fall1));

	////////////////////////////////////////////////////////////////////
	// wishbone slave
	// writes land on the edge that sees ack, reads clear on that edge
	assign idx = adr_i[ADR_W-1:2];
	assign wrHit = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	assign rdHit = cyc_i & stb_i & ~we_i & ack_o;
	assign wrByte = dat_i[7:0];

	// one wait state, ack dropped right after it was given
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			if (cyc_i & stb_i & ~ack_o) begin
				dat_o <= {24'h00_0000, regRead};
			end
		end
	end

	assign timerControlRegister = {timer1OverflowFlag, timer1RunBit,
		timer0OverflowFlag, timer0RunBit, 4'h0};

	// read mux; unmapped indices read zero
	always_comb begin
		if (idx == IDX_TCTRL) begin
			regRead = timerControlRegister;
		end else if (idx == IDX_TMODE) begin
			regRead = timerModeRegister;
		end else if (idx == IDX_T0LO) begin
			regRead = timer0LowByte;
		end else if (idx == IDX_T1LO) begin
			regRead = timer1LowByte;
		end else if (idx == IDX_T0HI) begin
			regRead = timer0HighByte;
		end else if (idx == IDX_T1HI) begin
			regRead = timer1HighByte;
		end else if (idx == IDX_IRQ_STAT) begin
			regRead = {6'h00, irqStatus};
		end else if (idx == IDX_IRQ_MASK) begin
			regRead = {6'h00, irqMask};
		end else begin
			regRead = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode register and its machine-cycle aligned copy
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timerModeRegister <= TMODE_RST;
		end else if (wrHit && idx == IDX_TMODE) begin
			timerModeRegister <= wrByte;
		end
	end

	// counting logic sees a new mode only at a machine cycle boundary
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modeActive <= TMODE_RST;
		end else if (tick) begin
			modeActive <= timerModeRegister;
		end
	end

	assign mode0 = timer_mode_t'(modeActive[TM_T0_MODE +: 2]);
	assign mode1 = timer_mode_t'(modeActive[TM_T1_MODE +: 2]);

	////////////////////////////////////////////////////////////////////
	// count enables
	// run bit qualified by the optional gate pin
	assign run0 = timer0RunBit & (~modeActive[TM_T0_GATE] | extIrq0Pin);
	assign run1 = timer1RunBit & (~modeActive[TM_T1_GATE] | extIrq1Pin);
	assign inc0 = run0 & (modeActive[TM_T0_SRC] ? fall0 : tick);
	assign inc1 = run1 & (mode1 != MODE_SPLIT)
		& (modeActive[TM_T1_SRC] ? fall1 : tick);
	// split high byte counts machine cycles under timer 1 run bit
	assign incHi0 = (mode0 == MODE_SPLIT) & timer1RunBit & tick;

	// one count step; result is {overflow, high, low}
	function automatic logic [16:0] stepTimer(input timer_mode_t m,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			MODE_PRESCALE: begin
				r[4:0] = lo[4:0] + 5'h01;
				if (lo[4:0] == 5'h1F) begin
					r[16:8] = {1'b0, hi} + 9'h001;
				end
			end
			MODE_CASCADE: begin
				r = {1'b0, hi, lo} + 17'h0_0001;
			end
			MODE_RELOAD: begin
				if (lo == 8'hFF) begin
					r = {1'b1, hi, hi};
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			default: begin
				{r[16], r[7:0]} = {1'b0, lo} + 9'h001;
			end
		endcase
		return r;
	endfunction

	assign step0 = stepTimer(mode0, timer0LowByte, timer0HighByte);
	assign step1 = stepTimer(mode1, timer1LowByte, timer1HighByte);
	assign ovf0 = inc0 & step0[16];
	// in split mode the timer 1 flag belongs to the timer 0 high byte
	assign ovf1 = (mode0 == MODE_SPLIT) ? (incHi0 & timer0HighByte == 8'hFF)
		: (inc1 & step1[16]);

	////////////////////////////////////////////////////////////////////
	// timer 0 data bytes; a software write beats a count
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer0LowByte <= COUNT_RST;
		end else if (wrHit && idx == IDX_T0LO) begin
			timer0LowByte <= wrByte;
		end else if (inc0) begin
			timer0LowByte <= step0[7:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer0HighByte <= COUNT_RST;
		end else if (wrHit && idx == IDX_T0HI) begin
			timer0HighByte <= wrByte;
		end else if (incHi0) begin
			timer0HighByte <= timer0HighByte + 8'h01;
		end else if (inc0 && mode0 != MODE_SPLIT) begin
			timer0HighByte <= step0[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////
	// timer 1 data bytes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer1LowByte <= COUNT_RST;
		end else if (wrHit && idx == IDX_T1LO) begin
			timer1LowByte <= wrByte;
		end else if (inc1) begin
			timer1LowByte <= step1[7:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer1HighByte <= COUNT_RST;
		end else if (wrHit && idx == IDX_T1HI) begin
			timer1HighByte <= wrByte;
		end else if (inc1) begin
			timer1HighByte <= step1[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////
	// control register: run bits and overflow flags
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer0RunBit <= TCTRL_RST[TC_TR0];
			timer1RunBit <= TCTRL_RST[TC_TR1];
		end else if (wrHit && idx == IDX_TCTRL) begin
			timer0RunBit <= wrByte[TC_TR0];
			timer1RunBit <= wrByte[TC_TR1];
		end
	end

	// a set in the same cycle as a clear wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer0OverflowFlag <= TCTRL_RST[TC_TF0];
			timer1OverflowFlag <= TCTRL_RST[TC_TF1];
		end else begin
			if (ovf0) begin
				timer0OverflowFlag <= 1'b1;
			end else if (vectorAck0) begin
				timer0OverflowFlag <= 1'b0;
			end else if (wrHit && idx == IDX_TCTRL) begin
				timer0OverflowFlag <= wrByte[TC_TF0];
			end
			if (ovf1) begin
				timer1OverflowFlag <= 1'b1;
			end else if (vectorAck1) begin
				timer1OverflowFlag <= 1'b0;
			end else if (wrHit && idx == IDX_TCTRL) begin
				timer1OverflowFlag <= wrByte[TC_TF1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt status, mask and output
	// sticky overflow events, cleared by reading, a new event wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqStatus <= IRQ_RST;
		end else begin
			irqStatus <= ((rdHit && idx == IDX_IRQ_STAT) ? 2'h0 : irqStatus)
				| {ovf1, ovf0};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqMask <= IRQ_RST;
		end else if (wrHit && idx == IDX_IRQ_MASK) begin
			irqMask <= wrByte[1:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_mode_write;
		wrHit && idx == IDX_TMODE |=> timerModeRegister == $past(wrByte);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write lost");
	property p_mode_apply;
		!tick |=> $stable(modeActive);
	endproperty
	a_mode_apply: assert property (p_mode_apply) else $error("mode changed off tick");
	property p_stop0;
		!timer0RunBit && !(wrHit && idx == IDX_T0LO) |=> $stable(timer0LowByte);
	endproperty
	a_stop0: assert property (p_stop0) else $error("timer 0 ran stopped");
	property p_gate0;
		modeActive[TM_T0_GATE] && !extIrq0Pin && !(wrHit && idx == IDX_T0LO)
			|=> $stable(timer0LowByte);
	endproperty
	a_gate0: assert property (p_gate0) else $error("timer 0 gate ignored");
	property p_gate1;
		modeActive[TM_T1_GATE] && !extIrq1Pin && !(wrHit && idx == IDX_T1LO)
			|=> $stable(timer1LowByte);
	endproperty
	a_gate1: assert property (p_gate1) else $error("timer 1 gate ignored");
	property p_split_stop1;
		mode1 == MODE_SPLIT && !wrHit |=> $stable({timer1HighByte, timer1LowByte});
	endproperty
	a_split_stop1: assert property (p_split_stop1) else $error("timer 1 ran in mode 3");
	property p_reload0;
		inc0 && mode0 == MODE_RELOAD && timer0LowByte == 8'hFF && !wrHit
			|=> timer0LowByte == $past(timer0HighByte) && timer0OverflowFlag;
	endproperty
	a_reload0: assert property (p_reload0) else $error("reload failed");
	property p_cascade0;
		inc0 && mode0 == MODE_CASCADE && !wrHit
			|=> {timer0HighByte, timer0LowByte}
			== $past({timer0HighByte, timer0LowByte}) + 16'h0001;
	endproperty
	a_cascade0: assert property (p_cascade0) else $error("cascade step wrong");
	// flag and sticky status both follow the overflow on the next edge
	property p_flag_set;
		ovf1 |=> timer1OverflowFlag && irqStatus[ST_OVF1];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("overflow flag missing");
	property p_tick_inc;
		inc0 && !modeActive[TM_T0_SRC] |-> tick;
	endproperty
	a_tick_inc: assert property (p_tick_inc) else $error("count off tick");
	c_reload: cover property (inc0 && mode0 == MODE_RELOAD && timer0LowByte == 8'hFF);
	c_split: cover property (ovf1 && mode0 == MODE_SPLIT);
	c_event: cover property (inc1 && modeActive[TM_T1_SRC]);
	c_irq: cover property (irq ##1 rdHit && idx == IDX_IRQ_STAT);
endmodule

// >>> core/dual_timer_pkg.sv
// constants and types shared by the dual timer block
package dual_timer_pkg;
	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_TCTRL = 8'h88;
	localparam logic [7:0] IDX_TMODE = 8'h89;
	localparam logic [7:0] IDX_T0LO = 8'h8A;
	localparam logic [7:0] IDX_T1LO = 8'h8B;
	localparam logic [7:0] IDX_T0HI = 8'h8C;
	localparam logic [7:0] IDX_T1HI = 8'h8D;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
	localparam int ADR_W = 10;
	// mode register fields
	localparam int TM_T1_GATE = 7;
	localparam int TM_T1_SRC = 6;
	localparam int TM_T1_MODE = 4;
	localparam int TM_T0_GATE = 3;
	localparam int TM_T0_SRC = 2;
	localparam int TM_T0_MODE = 0;
	// control register fields
	localparam int TC_TF1 = 7;
	localparam int TC_TR1 = 6;
	localparam int TC_TF0 = 5;
	localparam int TC_TR0 = 4;
	// status and mask fields
	localparam int ST_OVF0 = 0;
	localparam int ST_OVF1 = 1;
	// reset values
	localparam logic [7:0] TMODE_RST = 8'h00;
	localparam logic [7:0] TCTRL_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;
	// core clocks in one machine cycle
	localparam int MCYCLE_CLOCKS = 12;
	// operating modes of a timer
	typedef enum logic [1:0] {
		MODE_PRESCALE = 2'b00,
		MODE_CASCADE = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT = 2'b11
	} timer_mode_t;
endpackage

// >>> core/event_edge_sampler.sv
// samples an event pin once per machine cycle, pulses on high then low
`timescale 1ns/1ns
module event_edge_sampler (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic pin,
	output logic fall
);
	logic last;

	// one sample per tick; a high sample followed by a low one counts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			last <= 1'b0;
			fall <= 1'b0;
		end else begin
			if (tick) begin
				last <= pin;
			end
			fall <= tick & last & ~pin;
		end
	end

	property p_fall_after_tick;
		@(posedge ref_clk) disable iff (rst) fall |-> $past(tick);
	endproperty
	a_fall_after_tick: assert property (p_fall_after_tick) else $error("edge off tick");
endmodule

// >>> core/machine_cycle_gen.sv
// machine cycle tick generator: one pulse every DIV core clocks
`timescale 1ns/1ns
module machine_cycle_gen
	import dual_timer_pkg::*;
#(
	parameter int DIV = MCYCLE_CLOCKS
) (
	input wire logic ref_clk,
	input wire logic rst,
	output logic tick
);
	logic [7:0] phase;

	// free running phase counter, tick registered from the last phase, high while phase is zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase <= 8'h00;
			tick <= 1'b0;
		end else if (phase == 8'(DIV - 1)) begin
			phase <= 8'h00;
			tick <= 1'b1;
		end else begin
			phase <= phase + 8'h01;
			tick <= 1'b0;
		end
	end

	property p_tick_period;
		@(posedge ref_clk) disable iff (rst) tick |=> !tick ##11 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
endmodule

// >>> sim/dual_timer_bench.sv
// register-level bench for the dual timer block
`timescale 1ns/1ns
module dual_timer_bench
	import dual_timer_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst, cyc, stb, we, ack, irq, vack0, vack1;
	logic [3:0] sel;
	logic [ADR_W-1:0] adr;
	logic [31:0] wdat, rdat;
	logic e0, e1, t0, t1;
	logic [7:0] rd, v;
	int errTotal = 0;
	int cmpCount = 0;
	int cycles = 0;
	int mark, el;
	////////////////////////////////////////////////////////////////
	dual_timer dut (.ref_clk(ref_clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .dat_i(wdat), .sel_i(sel), .ack_o(ack), .dat_o(rdat),
		.extIrq0Pin(e0), .extIrq1Pin(e1), .timer0EventPin(t0), .timer1EventPin(t1),
		.vectorAck0(vack0), .vectorAck1(vack1), .irq(irq));
	event_pin_model pins (.ref_clk(ref_clk), .extIrq0Pin(e0), .extIrq1Pin(e1),
		.timer0EventPin(t0), .timer1EventPin(t1));
	// 250 MHz clock and hang guard
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errTotal++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////
	// one classic wishbone cycle, read byte lands in rd
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		@(posedge ref_clk);
		// no cycle count assumed; only the bench timeout ends a wait
		while (ack !== 1'b1) begin
			@(posedge ref_clk);
		end
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb(1'b1, idx, d, 4'h1);
	endtask
	task automatic chkByte(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chkRange(input string name, input int lo, input int hi,
		input logic [7:0] got);
		cmpCount++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			errTotal++;
			$display("Error %s expected %0d to %0d seen %h", name, lo, hi, got);
		end
	endtask
	task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00, 4'hF);
		chkByte(name, exp, rd);
	endtask
	// settle mode, send n events, let the count land
	task automatic ev(input int which, input int n);
		repeat (24) @(posedge ref_clk);
		pins.pulses(which, n, MCYCLE_CLOCKS);
		repeat (36) @(posedge ref_clk);
	endtask
	task automatic conclude();
		$display("compares %0d errors %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		adr = '0;
		wdat = '0;
		vack0 = 1'b0;
		vack1 = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		// reset values, unmapped place, byte-wide mode register
		rdc("mode", IDX_TMODE, TMODE_RST);
		rdc("control", IDX_TCTRL, TCTRL_RST);
		rdc("status", IDX_IRQ_STAT, 8'h00);
		wr(8'h00, 8'h5A);
		rdc("unmapped", 8'h00, 8'h00);
		wr(IDX_TMODE, 8'hA5);
		rdc("mode", IDX_TMODE, 8'hA5);
		wb(1'b1, IDX_TMODE, 8'h3C, 4'h0);
		rdc("mode", IDX_TMODE, 8'hA5);
		// timer 0 cascaded event counter
		wr(IDX_TMODE, 8'h05);
		wr(IDX_T0LO, 8'hFD);
		wr(IDX_T0HI, 8'h00);
		wr(IDX_TCTRL, 8'h10);
		ev(0, 5);
		rdc("t0 low", IDX_T0LO, 8'h02);
		rdc("t0 high", IDX_T0HI, 8'h01);
		// timer 0 auto-reload, flag, status, mask, vector clear
		wr(IDX_TMODE, 8'h06);
		wr(IDX_T0LO, 8'hFE);
		wr(IDX_T0HI, 8'h80);
		ev(0, 3);
		rdc("t0 low", IDX_T0LO, 8'h81);
		rdc("t0 high", IDX_T0HI, 8'h80);
		rdc("control", IDX_TCTRL, 8'h30);
		chkByte("irq", 8'h00, {7'h0, irq});
		wr(IDX_IRQ_MASK, 8'h01);
		repeat (2) @(posedge ref_clk);
		chkByte("irq", 8'h01, {7'h0, irq});
		rdc("status", IDX_IRQ_STAT, 8'h01);
		repeat (2) @(posedge ref_clk);
		chkByte("irq", 8'h00, {7'h0, irq});
		rdc("status", IDX_IRQ_STAT, 8'h00);
		vack0 <= 1'b1;
		@(posedge ref_clk);
		vack0 <= 1'b0;
		@(posedge ref_clk);
		rdc("control", IDX_TCTRL, 8'h10);
		// timer 0 gated prescaled counter
		wr(IDX_TMODE, 8'h0C);
		wr(IDX_T0LO, 8'h00);
		wr(IDX_T0HI, 8'h00);
		pins.gate(0, 1'b0);
		ev(0, 3);
		rdc("t0 low gated", IDX_T0LO, 8'h00);
		pins.gate(0, 1'b1);
		ev(0, 2);
		rdc("t0 low", IDX_T0LO, 8'h02);
		// timer 1 prescaler carry, then gate
		wr(IDX_TMODE, 8'h40);
		wr(IDX_T1LO, 8'h1E);
		wr(IDX_T1HI, 8'h00);
		wr(IDX_TCTRL, 8'h40);
		ev(1, 3);
		rdc("t1 high", IDX_T1HI, 8'h01);
		rdc("t1 low", IDX_T1LO, 8'h01);
		wr(IDX_TMODE, 8'hD0);
		pins.gate(1, 1'b0);
		ev(1, 2);
		rdc("t1 low gated", IDX_T1LO, 8'h01);
		pins.gate(1, 1'b1);
		ev(1, 2);
		rdc("t1 low", IDX_T1LO, 8'h03);
		// timer 1 reload, then stopped in mode 3
		wr(IDX_TMODE, 8'h60);
		wr(IDX_T1LO, 8'hFF);
		wr(IDX_T1HI, 8'h40);
		ev(1, 1);
		rdc("t1 low", IDX_T1LO, 8'h40);
		rdc("control", IDX_TCTRL, 8'hC0);
		// vector entry clears the timer 1 flag, run bit stays
		vack1 <= 1'b1;
		@(posedge ref_clk);
		vack1 <= 1'b0;
		@(posedge ref_clk);
		rdc("control", IDX_TCTRL, 8'h40);
		wr(IDX_TMODE, 8'h70);
		ev(1, 2);
		rdc("t1 low stopped", IDX_T1LO, 8'h40);
		// timer 0 split: low counts events, high counts machine cycles
		wr(IDX_TMODE, 8'h07);
		wr(IDX_T0LO, 8'h00);
		wr(IDX_T0HI, 8'h00);
		wr(IDX_TCTRL, 8'h50);
		mark = cycles;
		ev(0, 2);
		wr(IDX_TCTRL, 8'h00);
		el = (cycles - mark) / MCYCLE_CLOCKS;
		rdc("t0 low split", IDX_T0LO, 8'h02);
		wb(1'b0, IDX_T0HI, 8'h00, 4'hF);
		chkRange("t0 high ticks", el - 1, el + 1, rd);
		v = rd;
		repeat (48) @(posedge ref_clk);
		rdc("t0 high held", IDX_T0HI, v);
		// mid-run reset brings the registers back to zero
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdc("mode after reset", IDX_TMODE, TMODE_RST);
		rdc("control after reset", IDX_TCTRL, TCTRL_RST);
		rdc("t0 high after reset", IDX_T0HI, COUNT_RST);
		conclude();
	end
endmodule

// >>> sim/event_pin_model.sv
// gate levels and external event pulses seen by the timers
`timescale 1ns/1ns
module event_pin_model (
	input wire logic ref_clk,
	output logic extIrq0Pin,
	output logic extIrq1Pin,
	output logic timer0EventPin,
	output logic timer1EventPin
);
	// pins have pull-ups, so they idle high
	initial begin
		extIrq0Pin = 1'b1;
		extIrq1Pin = 1'b1;
		timer0EventPin = 1'b1;
		timer1EventPin = 1'b1;
	end
	// one event: low then high, each level held hold clocks (12 or more)
	task automatic pulses(input int which, input int n, input int hold);
		for (int i = 0; i < n; i++) begin
			if (which == 0) timer0EventPin <= 1'b0;
			else timer1EventPin <= 1'b0;
			repeat (hold) @(posedge ref_clk);
			if (which == 0) timer0EventPin <= 1'b1;
			else timer1EventPin <= 1'b1;
			repeat (hold) @(posedge ref_clk);
		end
	endtask
	// gate pin level
	task automatic gate(input int which, input logic lvl);
		if (which == 0) extIrq0Pin <= lvl;
		else extIrq1Pin <= lvl;
		@(posedge ref_clk);
	endtask
endmodule
